//--- hw/rmf_pkg.sv
// Notes on behaviour
// RULE1: Numeric op with emulate or switched flag: vector 7
// RULE2: Switched flag also traps wait with vector 7
// RULE3: Numeric operand over limit: vector 13, pointers kept
// RULE4: Pending numeric error gives vector 16, pointers stored
// RULE5: Vector 16 only numeric/wait, never no-wait controls
// RULE6: Vector 16 return points at instruction with prefixes
// RULE7: Reset enters real mode, 16-bit default size
// RULE8: Lock prefix outside permitted forms gives vector 6
// RULE9: Lock on repeated string is illegal
// RULE10: Lock legality ignores privilege level
// RULE11: Real mode uses A2-A19; A20-A31 high on code fetches until far transfer, low otherwise
// RULE12: Physical address is segment times 16 plus offset
// RULE13: Real segments are 64K, read/write/execute, unchecked
// RULE14: Byte past offset FFFF gives vector 13
// RULE15: Vector table at zero, four bytes per vector
// RULE16: Vectors 10, 11, 14 never raised in real mode
// RULE17: One exception per instruction attempt
package rmf_pkg;
   // Register byte offsets
   localparam logic [7:0]  ADDR_CTRL    = 8'h00;
   localparam logic [7:0]  ADDR_MODE    = 8'h04;
   localparam logic [7:0]  ADDR_STATUS  = 8'h08;
   localparam logic [7:0]  ADDR_MASK    = 8'h0C;
   localparam logic [7:0]  ADDR_NUMIP   = 8'h10;
   localparam logic [7:0]  ADDR_NUMDP   = 8'h14;
   localparam logic [7:0]  ADDR_NUMERR  = 8'h18;
   localparam logic [7:0]  ADDR_LASTEXC = 8'h1C;
   // Field positions
   localparam int          CTRL_EMU     = 0;
   localparam int          CTRL_TSW     = 1;
   localparam int          CTRL_BIG     = 2;
   localparam int          MODE_REAL    = 0;
   localparam int          MODE_FAR     = 1;
   localparam int          NST          = 4;
   localparam int          ST_UD        = 0;
   localparam int          ST_NM        = 1;
   localparam int          ST_GP        = 2;
   localparam int          ST_MF        = 3;
   // Reset values
   localparam logic [2:0]  CTRL_RST     = 3'h0;
   localparam logic [3:0]  MASK_RST     = 4'h0;
   // Vectors
   localparam logic [7:0]  VEC_UD       = 8'h06;
   localparam logic [7:0]  VEC_NM       = 8'h07;
   localparam logic [7:0]  VEC_TSS      = 8'h0A;
   localparam logic [7:0]  VEC_NP       = 8'h0B;
   localparam logic [7:0]  VEC_GP       = 8'h0D;
   localparam logic [7:0]  VEC_PF       = 8'h0E;
   localparam logic [7:0]  VEC_MF       = 8'h10;
   // Address space
   localparam logic [32:0] SEG_LIMIT    = 33'h0_0000_FFFF;
   localparam logic [31:0] PHYS_MAX     = 32'h0010_FFEF;
   localparam logic [11:0] HIGH_ONES    = 12'hFFF;
   // Instruction forms for lock checking
   typedef enum logic [2:0] {
      FORM_BITOP = 3'h0,
      FORM_XCHG  = 3'h1,
      FORM_ALU   = 3'h2,
      FORM_UNARY = 3'h3,
      FORM_OTHER = 3'h4
   } rmf_form_t;
endpackage : rmf_pkg

//--- hw/rmf_addr_gen.sv
`timescale 1ns/1ps
`default_nettype none
module rmf_addr_gen
   import rmf_pkg::*;
(
   // Logical address
   input  wire logic [15:0] seg,
   input  wire logic [31:0] offset,
   input  wire logic [1:0]  sizeCode,
   // Result
   output logic      [31:0] phys,
   output logic             limitFault
);
   logic [32:0] lastByte;
   logic [32:0] span;

   always_comb begin
      span = 33'h0_0000_0000;
      unique case (sizeCode)
         2'h0:    span = 33'h0_0000_0000;
         2'h1:    span = 33'h0_0000_0001;
         default: span = 33'h0_0000_0003;
      endcase
   end

   // No attribute checks: only the 64K bound matters [RULE13]
   assign lastByte   = {1'b0, offset} + span;
   assign limitFault = lastByte > SEG_LIMIT; // [RULE14]
   assign phys       = {12'h000, seg, 4'h0} + offset; // [RULE12]
endmodule : rmf_addr_gen
`default_nettype wire

//--- hw/rmf_lock_check.sv
`timescale 1ns/1ps
`default_nettype none
module rmf_lock_check
   import rmf_pkg::*;
(
   // Decoded prefix and form
   input  wire logic      lockPrefix,
   input  wire logic      repPrefix,
   input  wire rmf_form_t form,
   input  wire logic      memDest,
   input  wire logic      memOperand,
   // Verdict
   output logic           lockIllegal
);
   logic formOk;

   always_comb begin
      formOk = 1'b0;
      unique case (form)
         FORM_BITOP: formOk = memDest;
         FORM_XCHG:  formOk = memOperand;
         FORM_ALU:   formOk = memDest;
         FORM_UNARY: formOk = memDest;
         default:    formOk = 1'b0;
      endcase
   end

   // Privilege level deliberately plays no part [RULE10]
   // String repeats can page-fault midway, so never lockable [RULE9]
   assign lockIllegal = lockPrefix & (~formOk | repPrefix); // [RULE8]
endmodule : rmf_lock_check
`default_nettype wire

//--- hw/rmf_fault_unit.sv
`timescale 1ns/1ps
`default_nettype none
module rmf_fault_unit
   import rmf_pkg::*;
(
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            rst,
   // AHB-Lite slave
   input  wire logic            hsel,
   input  wire logic [31:0]     haddr,
   input  wire logic [1:0]      htrans,
   input  wire logic            hwrite,
   input  wire logic [2:0]      hsize,
   input  wire logic            hready,
   input  wire logic [31:0]     hwdata,
   output logic      [31:0]     hrdata,
   output logic                 hreadyout,
   output logic                 hresp,
   // Decoded instruction
   input  wire logic            instValid,
   input  wire logic [31:0]     instAddr,
   input  wire logic            instFp,
   input  wire logic            instWait,
   input  wire logic            instNoWait,
   input  wire logic            instNumClear,
   input  wire logic            lockPrefix,
   input  wire logic            repPrefix,
   input  wire rmf_pkg::rmf_form_t lockForm,
   input  wire logic            memDest,
   input  wire logic            memOperand,
   input  wire logic            opsizePrefix,
   input  wire logic            farXfer,
   // Fetch and operand addresses
   input  wire logic [15:0]     csSeg,
   input  wire logic [31:0]     fetchOffset,
   input  wire logic [1:0]      fetchSize,
   input  wire logic            csRelative,
   input  wire logic            opValid,
   input  wire logic [15:0]     opSeg,
   input  wire logic [31:0]     opOffset,
   input  wire logic [1:0]      opSize,
   // Numeric unit error report
   input  wire logic            numErr,
   input  wire logic [31:0]     numErrIp,
   input  wire logic [31:0]     numErrDp,
   // Exception and address outputs
   output logic                 excValid,
   output logic      [7:0]      excVector,
   output logic      [31:0]     excRetAddr,
   output logic      [31:0]     vecFetchAddr,
   output logic      [31:0]     busAddr,
   output logic                 effOpSize32,
   output logic                 irq
);
   import rmf_pkg::*;

   logic [2:0]  ctrl_reg,    ctrl_next;
   logic        real_reg,    real_next;
   logic        far_reg,     far_next;
   logic [3:0]  status_reg,  status_next;
   logic [3:0]  mask_reg,    mask_next;
   logic [31:0] numIp_reg,   numIp_next;
   logic [31:0] numDp_reg,   numDp_next;
   logic        errPend_reg, errPend_next;
   logic        excV_reg,    excV_next;
   logic [7:0]  excVec_reg,  excVec_next;
   logic [31:0] ret_reg,     ret_next;
   logic [31:0] bus_reg,     bus_next;
   logic [31:0] rd_reg,      rd_next;
   logic        wEn_reg,     wEn_next;
   logic [7:0]  wAddr_reg,   wAddr_next;
   logic [3:0]  setBits;
   logic [31:0] fetchPhys;
   logic [31:0] opPhys;
   logic        fetchFault;
   logic        opFault;
   logic        lockBad;
   logic        raise;
   logic [7:0]  vec;
   logic        addrPhase;

   rmf_addr_gen u_fetch (
      .seg        (csSeg),
      .offset     (fetchOffset),
      .sizeCode   (fetchSize),
      .phys       (fetchPhys),
      .limitFault (fetchFault)
   );

   rmf_addr_gen u_oper (
      .seg        (opSeg),
      .offset     (opOffset),
      .sizeCode   (opSize),
      .phys       (opPhys),
      .limitFault (opFault)
   );

   rmf_lock_check u_lock (
      .lockPrefix  (lockPrefix),
      .repPrefix   (repPrefix),
      .form        (lockForm),
      .memDest     (memDest),
      .memOperand  (memOperand),
      .lockIllegal (lockBad)
   );

   // Only 6, 7, 13 and 16 leave this chain, so 10, 11 and 14 never appear [RULE16]
   // Checks run in the core's fixed order so only one vector wins [RULE17]
   always_comb begin
      raise = 1'b1;
      vec   = VEC_GP;
      if (real_reg && fetchFault) begin
         vec = VEC_GP; // [RULE14]
      end else if (lockBad) begin
         vec = VEC_UD; // [RULE8] [RULE9]
      end else if (instWait && ctrl_reg[CTRL_TSW]) begin
         vec = VEC_NM; // [RULE2]
      end else if (instFp && (ctrl_reg[CTRL_EMU] || ctrl_reg[CTRL_TSW])) begin
         vec = VEC_NM; // [RULE1]
      end else if ((instFp || instWait) && !instNoWait && errPend_reg) begin
         vec = VEC_MF; // [RULE4] [RULE5]
      end else if (opValid && opFault && (instFp || real_reg)) begin
         vec = VEC_GP; // [RULE3] [RULE14]
      end else begin
         raise = 1'b0;
      end
   end

   // Bus slave: zero wait states, read data fetched during address phase
   assign addrPhase = hsel && hready && htrans[1];

   always_comb begin
      rd_next = rd_reg;
      if (addrPhase && !hwrite) begin
         unique case (haddr[7:0])
            ADDR_CTRL:    rd_next = {29'h0, ctrl_reg};
            ADDR_MODE:    rd_next = {30'h0, far_reg, real_reg};
            ADDR_STATUS:  rd_next = {28'h0, status_reg};
            ADDR_MASK:    rd_next = {28'h0, mask_reg};
            ADDR_NUMIP:   rd_next = numIp_reg;
            ADDR_NUMDP:   rd_next = numDp_reg;
            ADDR_NUMERR:  rd_next = {31'h0, errPend_reg};
            ADDR_LASTEXC: rd_next = {24'h0, excVec_reg};
            default:      rd_next = 32'h0000_0000;
         endcase
         if (haddr[31:8] != 24'h00_0000) begin
            rd_next = 32'h0000_0000;
         end
      end
   end

   assign wEn_next   = addrPhase && hwrite && (haddr[31:8] == 24'h00_0000);
   assign wAddr_next = addrPhase ? haddr[7:0] : wAddr_reg;

   always_comb begin
      ctrl_next    = ctrl_reg;
      real_next    = real_reg;
      far_next     = far_reg;
      mask_next    = mask_reg;
      numIp_next   = numIp_reg;
      numDp_next   = numDp_reg;
      errPend_next = errPend_reg;
      setBits      = 4'h0;
      status_next  = status_reg;
      if (wEn_reg) begin
         unique case (wAddr_reg)
            ADDR_CTRL: ctrl_next = hwdata[2:0];
            ADDR_MODE: real_next = hwdata[MODE_REAL];
            ADDR_MASK: mask_next = hwdata[3:0];
            default:   ctrl_next = ctrl_reg;
         endcase
      end
      if (instValid && farXfer && !raise) begin
         far_next = 1'b1; // [RULE11]
      end
      if (wEn_reg && (wAddr_reg == ADDR_NUMERR) && hwdata[0]) begin
         errPend_next = 1'b0;
      end
      if (instValid && instNumClear && !raise) begin
         errPend_next = 1'b0;
      end
      // Successful numeric op moves the pointers; a faulting one keeps them
      if (instValid && instFp && !raise) begin
         numIp_next = instAddr; // [RULE3]
         numDp_next = opPhys;
      end
      // Error report wins over clears in the same cycle
      if (numErr) begin
         errPend_next = 1'b1;
         numIp_next   = numErrIp; // [RULE4]
         numDp_next   = numErrDp;
      end
      if (instValid && raise) begin
         setBits[ST_UD] = vec == VEC_UD;
         setBits[ST_NM] = vec == VEC_NM;
         setBits[ST_GP] = vec == VEC_GP;
         setBits[ST_MF] = vec == VEC_MF;
      end
      if (wEn_reg && (wAddr_reg == ADDR_STATUS)) begin
         status_next = status_reg & ~hwdata[3:0];
      end
      status_next = status_next | setBits;
   end

   always_comb begin
      excV_next   = instValid && raise;
      excVec_next = excVec_reg;
      ret_next    = ret_reg;
      bus_next    = bus_reg;
      if (instValid) begin
         ret_next = instAddr; // [RULE6]
         if (raise) begin
            excVec_next = vec;
         end
      end
      if (opValid && !csRelative) begin
         bus_next = opPhys;
      end else if (csRelative) begin
         bus_next = fetchPhys;
      end
      if (real_reg) begin
         bus_next[31:20] = 12'h000; // [RULE11]
         bus_next[1:0]   = 2'h0;
         if (csRelative && !far_reg) begin
            bus_next[31:20] = HIGH_ONES;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_reg    <= CTRL_RST;
         real_reg    <= 1'b1; // [RULE7]
         far_reg     <= 1'b0;
         status_reg  <= 4'h0;
         mask_reg    <= MASK_RST;
         numIp_reg   <= 32'h0000_0000;
         numDp_reg   <= 32'h0000_0000;
         errPend_reg <= 1'b0;
         excV_reg    <= 1'b0;
         excVec_reg  <= 8'h00;
         ret_reg     <= 32'h0000_0000;
         bus_reg     <= 32'h0000_0000;
         rd_reg      <= 32'h0000_0000;
         wEn_reg     <= 1'b0;
         wAddr_reg   <= 8'h00;
      end else begin
         ctrl_reg    <= ctrl_next;
         real_reg    <= real_next;
         far_reg     <= far_next;
         status_reg  <= status_next;
         mask_reg    <= mask_next;
         numIp_reg   <= numIp_next;
         numDp_reg   <= numDp_next;
         errPend_reg <= errPend_next;
         excV_reg    <= excV_next;
         excVec_reg  <= excVec_next;
         ret_reg     <= ret_next;
         bus_reg     <= bus_next;
         rd_reg      <= rd_next;
         wEn_reg     <= wEn_next;
         wAddr_reg   <= wAddr_next;
      end
   end

   assign hrdata       = rd_reg;
   assign hreadyout    = 1'b1;
   assign hresp        = 1'b0;
   assign excValid     = excV_reg;
   assign excVector    = excVec_reg;
   assign excRetAddr   = ret_reg;
   assign busAddr      = bus_reg;
   assign vecFetchAddr = {22'h00_0000, excVec_reg, 2'h0}; // [RULE15]
   // Wide operands only through the prefix while in real mode [RULE7]
   assign effOpSize32  = opsizePrefix ^ (ctrl_reg[CTRL_BIG] & ~real_reg);
   assign irq          = |(status_reg & mask_reg);

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_fp_emul_vec: assert property (instValid && instFp && ctrl_reg[CTRL_EMU] // [RULE1]
      && !lockBad && !(real_reg && fetchFault) |=> excValid && excVector == VEC_NM)
      else $error("numeric op with emulate flag did not raise 7");
   a_wait_switch: assert property (instValid && instWait && ctrl_reg[CTRL_TSW] // [RULE2]
      && !lockBad && !(real_reg && fetchFault) |=> excValid && excVector == VEC_NM)
      else $error("wait with switched flag did not raise 7");
   a_fp_ptr_keep: assert property (excValid && !$past(numErr) |-> $stable(numIp_reg)) // [RULE3]
      else $error("numeric pointer moved on a faulting instruction");
   a_mf_cause: assert property (excValid && excVector == VEC_MF |-> $past(errPend_reg)) // [RULE4]
      else $error("vector 16 without pending numeric error");
   a_nowait_no_mf: assert property (instValid && instNoWait // [RULE5]
      |=> !(excValid && excVector == VEC_MF))
      else $error("no-wait control raised vector 16");
   a_ret_addr: assert property (instValid |=> excRetAddr == $past(instAddr)) // [RULE6]
      else $error("return address not the instruction start");
   a_reset_real: assert property ($past(rst) |-> real_reg && !far_reg // [RULE7]
      && (effOpSize32 == opsizePrefix))
      else $error("reset did not enter real mode");
   a_lock_rep: assert property (instValid && lockPrefix && repPrefix // [RULE9]
      && !(real_reg && fetchFault) |=> excValid && excVector == VEC_UD)
      else $error("locked string repeat not rejected");
   a_lock_other: assert property (instValid && lockPrefix && lockForm == FORM_OTHER // [RULE8]
      && !(real_reg && fetchFault) |=> excValid && excVector == VEC_UD)
      else $error("lock on an unlisted form not rejected");
   a_fetch_limit: assert property (instValid && real_reg && fetchFault // [RULE14]
      |=> excValid && excVector == VEC_GP)
      else $error("fetch past segment end did not raise 13");
   a_high_lines: assert property (real_reg && csRelative && !far_reg // [RULE11]
      |=> busAddr[31:20] == HIGH_ONES)
      else $error("high address lines not driven high");
   a_no_prot_vec: assert property (excValid && real_reg |-> excVector != VEC_TSS // [RULE16]
      && excVector != VEC_NP && excVector != VEC_PF)
      else $error("protected-mode vector raised in real mode");
   a_one_exc: assert property (excValid |-> $past(instValid)) // [RULE17]
      else $error("exception without an instruction attempt");

   c_nm: cover property (excValid && excVector == VEC_NM);
   c_mf: cover property (excValid && excVector == VEC_MF);
   c_ud: cover property (excValid && excVector == VEC_UD);
   c_gp: cover property (excValid && excVector == VEC_GP);
   c_irq: cover property (irq);
endmodule : rmf_fault_unit
`default_nettype wire

//--- tb/tb_rmf_fault_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_rmf_fault_unit;
   import rmf_pkg::*;
   typedef struct packed {
      logic        exc;
      logic [7:0]  vec;
      logic [31:0] ret;
      logic        chk;
      logic [31:0] bus;
   } rmf_note_t;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        hsel = 1'b0, hwrite = 1'b0, rdPend = 1'b0, attPrev = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0, instAddr = '0, fetchOffset = '0, opOffset = '0;
   logic [1:0]  htrans = '0, fetchSize = '0, opSize = '0;
   logic [2:0]  hsize = 3'h2;
   logic        instValid = 1'b0, instFp = 1'b0, instWait = 1'b0, instNoWait = 1'b0;
   logic        instNumClear = 1'b0, lockPrefix = 1'b0, repPrefix = 1'b0, memDest = 1'b0;
   logic        memOperand = 1'b0, opsizePrefix = 1'b0, farXfer = 1'b0, csRelative = 1'b0;
   logic        opValid = 1'b0, numErr = 1'b0;
   rmf_form_t   lockForm = FORM_OTHER;
   logic [15:0] csSeg = '0, opSeg = '0;
   logic [31:0] numErrIp = '0, numErrDp = '0;
   logic [31:0] hrdata, excRetAddr, vecFetchAddr, busAddr;
   logic        hreadyout, hresp, excValid, effOpSize32, irq;
   logic [7:0]  excVector;
   rmf_note_t   nq[$];
   logic [31:0] rq[$];
   rmf_note_t   note;
   logic [31:0] lastAddr, ip, dp, good, s, o;
   logic [20:0] p;
   int          seed = 68247;
   int          cyc = 0;
   int          fails = 0;
   int          checked = 0;

   rmf_fault_unit i_rmf_fault_unit (
      .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .instValid(instValid), .instAddr(instAddr), .instFp(instFp), .instWait(instWait),
      .instNoWait(instNoWait), .instNumClear(instNumClear), .lockPrefix(lockPrefix),
      .repPrefix(repPrefix), .lockForm(lockForm), .memDest(memDest),
      .memOperand(memOperand), .opsizePrefix(opsizePrefix), .farXfer(farXfer),
      .csSeg(csSeg), .fetchOffset(fetchOffset), .fetchSize(fetchSize),
      .csRelative(csRelative), .opValid(opValid), .opSeg(opSeg), .opOffset(opOffset),
      .opSize(opSize), .numErr(numErr), .numErrIp(numErrIp), .numErrDp(numErrDp),
      .excValid(excValid), .excVector(excVector), .excRetAddr(excRetAddr),
      .vecFetchAddr(vecFetchAddr), .busAddr(busAddr), .effOpSize32(effOpSize32), .irq(irq)
   );

   initial begin
      forever #5 clk = ~clk;
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checked = checked + 1;
      if (got !== exp) begin
         fails = fails + 1;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   task automatic end_of_test();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_of_test

   // One single AHB transfer; hready is always sampled before moving on
   task automatic bus(input logic w, input logic un, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] e);
      hsel <= 1'b1;
      haddr <= {23'h0, un, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      rdPend <= !w;
      if (!w)
         rq.push_back(e);
      do @(posedge clk); while (hreadyout !== 1'b1);
      rdPend <= 1'b0;
   endtask : bus

   // Fields are set by the caller in the same step; a gap cycle follows
   task automatic fire(input logic e, input logic [7:0] v, input logic c,
                       input logic [31:0] b);
      lastAddr = $random(seed);
      instAddr <= lastAddr;
      instValid <= 1'b1;
      nq.push_back({e, v, lastAddr, c, b});
      @(posedge clk);
      instValid <= 1'b0;
      {instFp, instWait, instNoWait, instNumClear, lockPrefix, repPrefix} <= '0;
      {opValid, csRelative, farXfer} <= '0;
      @(posedge clk);
   endtask : fire

   always @(posedge clk) begin
      attPrev <= instValid;
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails = fails + 1;
         end_of_test();
      end
   end

   // Results are looked at mid-cycle, well clear of the launching edge
   always @(negedge clk) begin
      if (rdPend && hreadyout === 1'b1 && rq.size() > 0) begin
         cmp(hrdata, rq.pop_front());
         cmp({31'h0, hresp}, 32'h0);
      end
      if (attPrev && nq.size() > 0) begin
         note = nq.pop_front();
         cmp({31'h0, excValid}, {31'h0, note.exc});
         cmp(excRetAddr, note.ret);
         if (note.exc) begin
            cmp({24'h0, excVector}, {24'h0, note.vec});
            cmp(vecFetchAddr, {22'h0, note.vec, 2'b00});
         end
         if (note.chk)
            cmp(busAddr, note.bus);
      end else
         cmp({31'h0, excValid}, 32'h0);
   end

   initial begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, 1'b0, ADDR_MODE, '0, 32'h1);
      bus(1'b0, 1'b0, ADDR_STATUS, '0, 32'h0);
      bus(1'b1, 1'b0, ADDR_CTRL, 32'h4, '0);
      @(posedge clk);
      cmp({31'h0, effOpSize32}, 32'h0);
      opsizePrefix <= 1'b1;
      @(posedge clk);
      cmp({31'h0, effOpSize32}, 32'h1);
      opsizePrefix <= 1'b0;
      for (int f = 0; f < 5; f++) begin
         for (int k = 0; k < 8; k++) begin
            lockPrefix <= 1'b1;
            repPrefix <= k[2];
            memDest <= k[1];
            memOperand <= k[0];
            lockForm <= rmf_form_t'(f);
            fire(k[2] || (f == 1 ? !k[0] : (f == 4 || !k[1])), VEC_UD, 1'b0, '0);
         end
      end
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, 1'b0, ADDR_CTRL, c, '0);
         instFp <= 1'b1;
         fire(c != 0, VEC_NM, 1'b0, '0);
         instWait <= 1'b1;
         fire(c[1], VEC_NM, 1'b0, '0);
      end
      bus(1'b1, 1'b0, ADDR_CTRL, 32'h0, '0);
      ip = $random(seed);
      dp = $random(seed);
      numErr <= 1'b1;
      numErrIp <= ip;
      numErrDp <= dp;
      @(posedge clk);
      numErr <= 1'b0;
      bus(1'b0, 1'b0, ADDR_NUMERR, '0, 32'h1);
      bus(1'b0, 1'b0, ADDR_NUMIP, '0, ip);
      bus(1'b0, 1'b0, ADDR_NUMDP, '0, dp);
      instWait <= 1'b1;
      fire(1'b1, VEC_MF, 1'b0, '0);
      instFp <= 1'b1;
      fire(1'b1, VEC_MF, 1'b0, '0);
      instFp <= 1'b1;
      instNoWait <= 1'b1;
      fire(1'b0, VEC_MF, 1'b0, '0);
      instFp <= 1'b1;
      instNoWait <= 1'b1;
      instNumClear <= 1'b1;
      fire(1'b0, VEC_MF, 1'b0, '0);
      bus(1'b0, 1'b0, ADDR_NUMERR, '0, 32'h0);
      instFp <= 1'b1;
      fire(1'b0, VEC_MF, 1'b0, '0);
      good = lastAddr;
      instFp <= 1'b1;
      opValid <= 1'b1;
      opOffset <= 32'h0000_FFFD;
      opSize <= 2'h2;
      fire(1'b1, VEC_GP, 1'b0, '0);
      bus(1'b0, 1'b0, ADDR_NUMIP, '0, good);
      repeat (6) begin
         s = $random(seed);
         o = $random(seed);
         p = {1'b0, s[15:0], 4'h0} + {5'h0, o[15:0]};
         opSeg <= s[15:0];
         opOffset <= {16'h0, o[15:0]};
         opSize <= 2'h0;
         opValid <= 1'b1;
         fire(1'b0, VEC_GP, 1'b1, {12'h0, p[19:2], 2'b00});
      end
      opOffset <= 32'h0000_FFFF;
      opSize <= 2'h1;
      opValid <= 1'b1;
      fire(1'b1, VEC_GP, 1'b0, '0);
      opSize <= 2'h0;
      opValid <= 1'b1;
      fire(1'b0, VEC_GP, 1'b0, '0);
      opOffset <= 32'h0001_0000;
      opValid <= 1'b1;
      fire(1'b1, VEC_GP, 1'b0, '0);
      fetchOffset <= 32'h0000_FFFE;
      fetchSize <= 2'h2;
      fire(1'b1, VEC_GP, 1'b0, '0);
      csSeg <= s[15:0];
      fetchOffset <= {16'h0, o[15:0]};
      fetchSize <= 2'h0;
      csRelative <= 1'b1;
      fire(1'b0, VEC_GP, 1'b1, {12'hFFF, p[19:2], 2'b00});
      farXfer <= 1'b1;
      fire(1'b0, VEC_GP, 1'b0, '0);
      bus(1'b0, 1'b0, ADDR_MODE, '0, 32'h3);
      csRelative <= 1'b1;
      fire(1'b0, VEC_GP, 1'b1, {12'h000, p[19:2], 2'b00});
      // Every event kind has fired by now, so all four sticky bits stand
      bus(1'b0, 1'b0, ADDR_STATUS, '0, 32'hF);
      cmp({31'h0, irq}, 32'h0);
      bus(1'b1, 1'b0, ADDR_MASK, 32'h4, '0);
      repeat (2) @(posedge clk);
      cmp({31'h0, irq}, 32'h1);
      bus(1'b0, 1'b0, ADDR_MASK, '0, 32'h4);
      bus(1'b1, 1'b0, ADDR_STATUS, 32'h4, '0);
      repeat (2) @(posedge clk);
      cmp({31'h0, irq}, 32'h0);
      bus(1'b0, 1'b0, ADDR_STATUS, '0, 32'hB);
      bus(1'b1, 1'b1, ADDR_CTRL, 32'h3, '0);
      bus(1'b0, 1'b1, ADDR_CTRL, '0, 32'h0);
      bus(1'b0, 1'b0, ADDR_CTRL, '0, 32'h0);
      bus(1'b0, 1'b0, ADDR_LASTEXC, '0, {24'h0, VEC_GP});
      // Leaving real mode lets the big default size through
      bus(1'b1, 1'b0, ADDR_MODE, 32'h0, '0);
      bus(1'b1, 1'b0, ADDR_CTRL, 32'h4, '0);
      @(posedge clk);
      cmp({31'h0, effOpSize32}, 32'h1);
      repeat (2) @(posedge clk);
      end_of_test();
   end
endmodule : tb_rmf_fault_unit
`default_nettype wire
